// *** pkg/als_irq_defs.svh ***
// register offsets, field positions and reset values of the alert block
`ifndef ALS_IRQ_DEFS_SVH
`define ALS_IRQ_DEFS_SVH
// ---------------------------------------------------------------------
// byte offsets on the register bus
// ---------------------------------------------------------------------
`define ADR_CFG      8'h00
`define ADR_HIGH     8'h04
`define ADR_LOW      8'h08
`define ADR_IRQ_ST   8'h0c
`define ADR_IRQ_MSK  8'h10
// ---------------------------------------------------------------------
// configuration register fields
// ---------------------------------------------------------------------
`define CFG_FC_HI    1
`define CFG_FC_LO    0
`define CFG_SENSE    3
`define CFG_LATCH    4
`define CFG_FL       5
`define CFG_FH       6
`define CFG_RDY      7
`define CFG_MODE_HI  10
`define CFG_MODE_LO  9
// limit word: exponent on top, mantissa below
`define LIM_EXP_HI   15
`define LIM_EXP_LO   12
`define LIM_MAN_HI   11
`define EOC_SEL_HI   15
`define EOC_SEL_LO   14
`define EOC_CODE     2'b11
// interrupt status bits
`define IRQ_CONV     0
`define IRQ_HIGH     1
`define IRQ_LOW      2
// reset values
`define RST_HIGH     16'hbfff
`define RST_LOW      16'h0000
`define RST_FC       2'h0
`define RST_IRQ      3'h0
`endif

// *** pkg/als_irq_pkg.sv ***
// types shared by the light threshold alert logic
package als_irq_pkg;
  // operating select field; zero means shutdown
  typedef enum logic [1:0] {
    OP_SHUTDOWN,
    OP_SINGLE,
    OP_CONT_A,
    OP_CONT_B
  } op_mode_t;
  // exponent/mantissa limit or result word
  typedef logic [15:0] lim_word_t;
endpackage : als_irq_pkg

// *** design/light_threshold_irq.sv ***
// light threshold alert logic with wishbone registers
// Contract
// - transparent high fault: pin active, high set
// - transparent low fault: pin inactive, low set
// - transparent: config access leaves flags, pin
// - transparent modes ignore alert response
// - every completion sets conversion ready
// - config read clears conversion ready
// - non-shutdown config write clears conversion ready
// - shutdown config write leaves flags and conversion ready
// - pin level follows state and output sense
// - eoc_select_bits equal 11b selects end-of-conversion
// - end-of-conversion: pin active every completion
// - eoc pin cleared by read, non-shutdown write, latched alert
// - eoc latched: high sets; read clears both
// - eoc latched: low sets; alert keeps flags
// - latch bit four picks latched window
// - latched: read clears all; alert pin only
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "als_irq_defs.svh"
module light_threshold_irq #(
  parameter int FC_W  = 2,   // width of fault count field
  parameter int CNT_W = 3    // width of consecutive counters
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // conversion results and alert response
  input  wire logic [15:0] RESULT,
  input  wire logic        RESULT_VALID,
  input  wire logic        ALERT_RESP,
  // outputs
  output logic             INT_PIN,
  output logic             IRQ,
  output logic      [1:0]  OP_MODE
);
  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [FC_W-1:0]        fc;        // fault count field
  logic                   output_sense_select; // pin sense
  logic                   latch;     // latch select
  als_irq_pkg::lim_word_t hi_lim;    // high limit
  als_irq_pkg::lim_word_t lo_lim;    // low limit
  logic                   fh;        // flag high
  logic                   fl;        // flag low
  logic                   rdy;       // conversion ready
  logic                   pin_state; // pin active
  logic [CNT_W-1:0]       hi_cnt;    // consecutive high faults
  logic [CNT_W-1:0]       lo_cnt;    // consecutive low faults
  logic [2:0]             irq_st;    // sticky events
  logic [2:0]             irq_msk;   // event mask
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // exponent/mantissa word to a linear value for comparison
  function automatic logic [26:0] to_lin(input logic [15:0] w);
    return {15'h0000, w[`LIM_MAN_HI:0]} << w[`LIM_EXP_HI:`LIM_EXP_LO];
  endfunction : to_lin
  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] o,
    input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge16
  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  wire take    = WB_CYC_I & WB_STB_I & ~WB_ACK_O; // one take per access
  wire wr      = take & WB_WE_I;
  wire rd      = take & ~WB_WE_I;
  wire sel_cfg = (WB_ADR_I == `ADR_CFG);
  wire cfg_rd  = rd & sel_cfg;
  wire cfg_wr  = wr & sel_cfg;
  wire wr_hi   = wr & (WB_ADR_I == `ADR_HIGH);
  wire wr_lo   = wr & (WB_ADR_I == `ADR_LOW);
  wire wr_st   = wr & (WB_ADR_I == `ADR_IRQ_ST) & WB_SEL_I[0];
  wire wr_msk  = wr & (WB_ADR_I == `ADR_IRQ_MSK) & WB_SEL_I[0];
  // mode field of a config write; only written when its lane is set
  wire [1:0] wr_mode = WB_SEL_I[1] ?
                       WB_DAT_I[`CFG_MODE_HI:`CFG_MODE_LO] : OP_MODE;
  wire wr_shut = (wr_mode == als_irq_pkg::OP_SHUTDOWN);
  wire wr_lat  = WB_SEL_I[0] ? WB_DAT_I[`CFG_LATCH] : latch;
  wire alert   = ALERT_RESP;
  wire conv    = RESULT_VALID;
  // end-of-conversion select from the top two exponent bits of the low limit
  wire eoc = (lo_lim[`EOC_SEL_HI:`EOC_SEL_LO] == `EOC_CODE);
  // -------------------------------------------------------------------
  // comparison and consecutive counting
  // -------------------------------------------------------------------
  wire [26:0] res_lin = to_lin(RESULT);
  wire hi_viol = res_lin > to_lin(hi_lim);
  wire lo_viol = res_lin < to_lin(lo_lim);
  // field n asks for n+1 faults in a row
  wire [CNT_W-1:0] need = CNT_W'(fc) + CNT_W'(1);
  wire [CNT_W-1:0] hi_inc = hi_cnt + CNT_W'(1);
  wire [CNT_W-1:0] lo_inc = lo_cnt + CNT_W'(1);
  wire hi_hit = conv & hi_viol & (hi_inc >= need);
  wire lo_hit = conv & lo_viol & (lo_inc >= need);
  // saturate so a long fault keeps reporting on every conversion
  wire [CNT_W-1:0] next_hi_cnt = !hi_viol ? '0 :
                                 (hi_inc >= need) ? hi_cnt : hi_inc;
  wire [CNT_W-1:0] next_lo_cnt = !lo_viol ? '0 :
                                 (lo_inc >= need) ? lo_cnt : lo_inc;
  // counters restart on any clean conversion
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
    end else if (conv) begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end
  // -------------------------------------------------------------------
  // flag, ready and pin next state: clears first, sets win
  // -------------------------------------------------------------------
  logic next_fh, next_fl, next_rdy, next_pin; // next status values
  always_comb begin
    next_fh  = fh;
    next_fl  = fl;
    next_rdy = rdy;
    next_pin = pin_state;
    // transparent modes keep flags and pin on config access
    if (cfg_rd) begin
      next_rdy = 1'b0;
      if (latch) begin
        next_fh  = 1'b0;
        next_fl  = 1'b0;
      end
      if (latch || eoc) begin
        next_pin = 1'b0;
      end
    end
    // shutdown writes fall through untouched
    if (cfg_wr && !wr_shut) begin
      next_rdy = 1'b0;
      if (eoc) begin
        next_pin = 1'b0;
      end
    end
    // dropping latch is the way out of a stuck latched pin
    if (cfg_wr && latch && !wr_lat) begin
      next_pin = 1'b0;
    end
    // alert response only touches the pin, only when latched
    if (alert && latch) begin
      next_pin = 1'b0;
    end
    // conversion events override any clear in the same cycle
    if (conv) begin
      next_rdy = 1'b1;
      if (hi_hit) begin // high wins on overlapping limits
        next_fh  = 1'b1;
        next_pin = 1'b1;
        if (!latch) begin
          next_fl = 1'b0;
        end
      end else if (lo_hit) begin
        next_fl  = 1'b1;
        next_pin = latch;
        if (!latch) begin
          next_fh = 1'b0;
        end
      end
      if (eoc) begin
        next_pin = 1'b1;
      end
    end
  end
  wire next_sense = (cfg_wr && WB_SEL_I[0]) ? WB_DAT_I[`CFG_SENSE] :
                    output_sense_select;
  // -------------------------------------------------------------------
  // status registers and pin
  // -------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fh        <= 1'b0;
      fl        <= 1'b0;
      rdy       <= 1'b0;
      pin_state <= 1'b0;
      INT_PIN   <= 1'b1; // inactive with active-low sense
    end else begin
      fh        <= next_fh;
      fl        <= next_fl;
      rdy       <= next_rdy;
      pin_state <= next_pin;
      INT_PIN   <= ~(next_pin ^ next_sense);
    end
  end
  // -------------------------------------------------------------------
  // writable configuration and limits
  // -------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fc      <= FC_W'(`RST_FC);
      output_sense_select <= 1'b0;
      latch   <= 1'b0;
      OP_MODE <= als_irq_pkg::OP_SHUTDOWN;
      hi_lim  <= `RST_HIGH;
      lo_lim  <= `RST_LOW;
    end else begin
      if (cfg_wr) begin
        output_sense_select <= next_sense;
        latch   <= wr_lat;
        OP_MODE <= wr_mode;
        if (WB_SEL_I[0]) begin
          fc <= WB_DAT_I[`CFG_FC_HI:`CFG_FC_LO];
        end
      end
      if (wr_hi) begin
        hi_lim <= merge16(hi_lim, WB_DAT_I, WB_SEL_I);
      end
      if (wr_lo) begin
        lo_lim <= merge16(lo_lim, WB_DAT_I, WB_SEL_I);
      end
    end
  end
  // -------------------------------------------------------------------
  // interrupt status, mask and line
  // -------------------------------------------------------------------
  wire [2:0] ev;
  assign ev[`IRQ_CONV] = conv;
  assign ev[`IRQ_HIGH] = hi_hit;
  assign ev[`IRQ_LOW]  = lo_hit;
  // write one clears; a new event in the same cycle stays set
  wire [2:0] st_clr    = wr_st ? WB_DAT_I[2:0] : 3'h0;
  wire [2:0] next_st   = (irq_st & ~st_clr) | ev;
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_st  <= `RST_IRQ;
      irq_msk <= `RST_IRQ;
      IRQ     <= 1'b0;
    end else begin
      irq_st <= next_st;
      if (wr_msk) begin
        irq_msk <= WB_DAT_I[2:0];
      end
      IRQ <= |(next_st & (wr_msk ? WB_DAT_I[2:0] : irq_msk));
    end
  end
  // -------------------------------------------------------------------
  // read path; unmapped addresses read zero and still ack
  // -------------------------------------------------------------------
  logic [31:0] cfg_word;
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`CFG_FC_HI:`CFG_FC_LO]     = fc;
    cfg_word[`CFG_SENSE]                = output_sense_select;
    cfg_word[`CFG_LATCH]                = latch;
    cfg_word[`CFG_FL]                   = fl;
    cfg_word[`CFG_FH]                   = fh;
    cfg_word[`CFG_RDY]                  = rdy;
    cfg_word[`CFG_MODE_HI:`CFG_MODE_LO] = OP_MODE;
  end
  wire [31:0] rd_mux =
    sel_cfg                     ? cfg_word :
    (WB_ADR_I == `ADR_HIGH)     ? {16'h0000, hi_lim} :
    (WB_ADR_I == `ADR_LOW)      ? {16'h0000, lo_lim} :
    (WB_ADR_I == `ADR_IRQ_ST)   ? {29'h0, irq_st} :
    (WB_ADR_I == `ADR_IRQ_MSK)  ? {29'h0, irq_msk} : 32'h0000_0000;
  // one wait state; ack drops the cycle after it rises
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= take;
      if (rd) begin
        WB_DAT_O <= rd_mux;
      end
    end
  end
  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  sequence s_rd_quiet;
    cfg_rd && !conv && !alert;
  endsequence
  sequence s_flags_kept;
    $stable(fh) && $stable(fl);
  endsequence
  AST_TRANS_HIGH: assert property (
    conv && hi_hit && !latch |=> fh && !fl && pin_state)
    else $error("transparent high fault not reported");
  AST_TRANS_LOW: assert property (
    conv && lo_hit && !hi_hit && !latch && !eoc
      |=> fl && !fh && !pin_state)
    else $error("transparent low fault not reported");
  AST_TRANS_HOLD: assert property (
    s_rd_quiet and (!latch && !eoc) |=> s_flags_kept and $stable(pin_state))
    else $error("transparent flags moved on config read");
  AST_ALERT_IGN: assert property (
    alert && !latch && !conv && !take |=> $stable(pin_state) && $stable(rdy))
    else $error("alert response acted in transparent mode");
  AST_READY_SET: assert property (
    conv |=> rdy)
    else $error("conversion ready not set");
  AST_READY_RD: assert property (
    cfg_rd && !conv |=> !rdy ##1 !rdy || $past(conv))
    else $error("conversion ready not cleared by read");
  AST_WR_RUN: assert property (
    cfg_wr && !wr_shut && !conv |=> !rdy)
    else $error("run write kept conversion ready");
  AST_WR_SHUT: assert property (
    cfg_wr && wr_shut && !conv |=> s_flags_kept and $stable(rdy))
    else $error("shutdown write changed status");
  AST_PIN_LEVEL: assert property (
    INT_PIN == ~(pin_state ^ output_sense_select))
    else $error("pin level disagrees with state and sense");
  AST_EOC_SET: assert property (
    conv && eoc |=> pin_state)
    else $error("eoc pin not set at completion");
  AST_EOC_RD: assert property (
    s_rd_quiet and eoc |=> !pin_state)
    else $error("eoc pin not cleared by read");
  AST_LATCH_RD: assert property (
    s_rd_quiet and latch |=> !fh && !fl && !pin_state)
    else $error("latched read did not clear flags");
  AST_LATCH_ALERT: assert property (
    alert && latch && !conv && !take |=> !pin_state and s_flags_kept)
    else $error("alert response mishandled when latched");
  AST_CNT_RESTART: assert property (
    conv && !hi_viol |=> hi_cnt == '0)
    else $error("high counter did not restart");
endmodule : light_threshold_irq

// *** verif/conv_source.sv ***
// conversion result source standing in for the light front end
`timescale 1ns/1ps
module conv_source (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request from the bench
  input  wire logic        go,
  input  wire logic [15:0] val,
  // completion toward the alert logic
  output logic      [15:0] result,
  output logic             result_valid
);
  // ---------------------------------------------------------------
  // one completion pulse per request
  // ---------------------------------------------------------------
  // between completions the word is scrambled every cycle, so any
  // sampling of a stale result shows up as a wrong flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result       <= 16'h0000;
      result_valid <= 1'b0;
    end else if (go) begin
      result       <= val;
      result_valid <= 1'b1;
    end else begin
      result       <= ~result;
      result_valid <= 1'b0;
    end
  end
endmodule : conv_source

// *** verif/tb.sv ***
// self-checking bench of the light threshold alert logic
`timescale 1ns/1ps
`include "als_irq_defs.svh"
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin mismatches++; \
  $display("unexpected at %0t got %h want %h", $time, g, w); end end
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk, rst;           // clock, async reset
  logic        cyc, stb, we, ack;  // wishbone handshake
  logic [7:0]  adr;                // byte address
  logic [3:0]  sel;                // byte lanes, low half only
  logic [31:0] dat_w, dat_r, q;    // write, read, last read
  logic [15:0] val, res, hi, lo;   // results and limits
  logic        go, res_v, alert;   // completion request, pulses
  logic        int_pin, irq;       // outputs under test
  logic [1:0]  op_mode;            // mode as the design holds it
  logic        act, fh, fl, sense; // reference pin state and flags
  int          hc, lc, fc;         // reference fault counting
  int          mismatches, checked;
  // ---------------------------------------------------------------
  // partner and design
  // ---------------------------------------------------------------
  conv_source src (.clk(clk), .rst(rst), .go(go), .val(val),
    .result(res), .result_valid(res_v));
  light_threshold_irq dut (.CLK_SYS(clk), .SYS_RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .RESULT(res),
    .RESULT_VALID(res_v), .ALERT_RESP(alert), .INT_PIN(int_pin),
    .IRQ(irq), .OP_MODE(op_mode));
  // ---------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------
  // linear light value of an exponent/mantissa word
  function automatic int lin(input logic [15:0] w);
    return int'(w[11:0]) << w[15:12];
  endfunction : lin
  // pin level of a pin state under the current output sense
  function automatic logic pin(input logic a);
    return a ? sense : ~sense;
  endfunction : pin
  // configuration word: mode, latch, output sense, fault count
  function automatic logic [31:0] cfg(input als_irq_pkg::op_mode_t m,
                                      input logic l, input int f);
    return {21'h0, m, 4'h0, l, sense, 1'b0, 2'(f)};
  endfunction : cfg
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      mismatches++;
      close_out();
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    #1;
  endtask : wb
  // both limits; low goes last so mode changes land together
  task automatic lim(input logic [15:0] h, input logic [15:0] l);
    hi = h;
    lo = l;
    wb(1'b1, `ADR_HIGH, {16'h0, h});
    wb(1'b1, `ADR_LOW, {16'h0, l});
  endtask : lim
  // one completion, then the transparent reference steps
  task automatic conv(input logic [15:0] v);
    @(posedge clk);
    go  <= 1'b1;
    val <= v;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    hc = (lin(v) > lin(hi)) ? hc + 1 : 0;
    lc = (lin(v) < lin(lo)) ? lc + 1 : 0;
    if (hc > fc) begin
      {act, fh, fl} = 3'b110;
    end else if (lc > fc) begin
      {act, fh, fl} = 3'b001;
    end
  endtask : conv
  // alert response pulse of one cycle
  task automatic alert_pulse;
    @(posedge clk);
    alert <= 1'b1;
    @(posedge clk);
    alert <= 1'b0;
    @(posedge clk);
    #1;
  endtask : alert_pulse
  // verdict and end of run
  task automatic close_out;
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // ---------------------------------------------------------------
  // clock and sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst, sel} = 5'h13;
    {cyc, stb, we, go, alert, act, fh, fl, sense} = 9'h0;
    {adr, dat_w, val, hi, lo} = {8'h0, 32'h0, 16'h0, 16'hbfff, 16'h0};
    {hc, lc, fc, mismatches, checked} = '0;
    void'($urandom(55539));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    // reset values and unmapped space
    `CHK(int_pin, 1'b1)
    `CHK(op_mode, 2'h0)
    wb(1'b0, `ADR_HIGH, 0);
    `CHK(q, 32'h0000bfff)
    wb(1'b1, 8'h14, 32'hffff);
    wb(1'b0, 8'h14, 0);
    `CHK(q, 32'h0)
    // interrupt raised, masked and cleared
    wb(1'b1, `ADR_IRQ_MSK, 32'h1);
    conv(16'h0400);
    `CHK(irq, 1'b1)
    wb(1'b0, `ADR_IRQ_ST, 0);
    `CHK(q, 32'h1)
    wb(1'b1, `ADR_IRQ_MSK, 32'h0);
    `CHK(irq, 1'b0)
    wb(1'b1, `ADR_IRQ_ST, 32'h1);
    wb(1'b0, `ADR_IRQ_ST, 0);
    `CHK(q, 32'h0)
    // transparent mode, random results, every fault count
    lim(16'h0800, 16'h0200);
    for (int f = 0; f < 4; f++) begin
      fc = f;
      sense = 1'($urandom_range(1));
      wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_CONT_A, 1'b0, f));
      `CHK(int_pin, pin(act))
      conv(16'h0400); // in-band result restarts both counters
      repeat (12) begin
        conv({4'($urandom_range(3)), 12'($urandom)});
        `CHK(int_pin, pin(act))
      end
      wb(1'b0, `ADR_CFG, 0);
      `CHK(q[7:5], {1'b1, fh, fl})
      wb(1'b0, `ADR_CFG, 0);
      `CHK(q[7:5], {1'b0, fh, fl})
      alert_pulse();
      `CHK(int_pin, pin(act))
    end
    // ready field against shutdown and normal writes
    conv(16'h0400);
    wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_SHUTDOWN, 1'b0, fc));
    `CHK(op_mode, 2'h0)
    `CHK(int_pin, pin(act))
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[7:5], {1'b1, fh, fl})
    conv(16'h0400);
    wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_CONT_B, 1'b0, fc));
    `CHK(int_pin, pin(act))
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[7:5], {1'b0, fh, fl})
    // end-of-conversion with latched window
    sense = 1'b0;
    lim(16'hc100, 16'hc001);
    wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_CONT_A, 1'b1, 0));
    wb(1'b0, `ADR_CFG, 0);
    wb(1'b0, `ADR_CFG, 0);
    `CHK(int_pin, 1'b1)
    conv(16'h3800);
    `CHK(int_pin, 1'b0)
    wb(1'b0, `ADR_CFG, 0);
    `CHK(int_pin, 1'b1)
    conv(16'h3800);
    alert_pulse();
    `CHK(int_pin, 1'b1)
    conv(16'h3800);
    wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_CONT_A, 1'b1, 0));
    `CHK(int_pin, 1'b1)
    conv(16'hf0ff);
    conv(16'h0000);
    alert_pulse();
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[6:5], 2'b11)
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[7:5], 3'b000)
    // leaving end-of-conversion takes a latch clear
    conv(16'h3800);
    lim(16'h0800, 16'h0200);
    wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_CONT_A, 1'b0, 0));
    `CHK(int_pin, 1'b1)
    wb(1'b1, `ADR_CFG, cfg(als_irq_pkg::OP_CONT_A, 1'b1, 0));
    // latched window: faults hold until a read
    conv(16'h0900);
    `CHK(int_pin, 1'b0)
    conv(16'h0400);
    `CHK(int_pin, 1'b0)
    alert_pulse();
    `CHK(int_pin, 1'b1)
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[6:5], 2'b10)
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[6:5], 2'b00)
    conv(16'h0001);
    `CHK(int_pin, 1'b0)
    wb(1'b0, `ADR_CFG, 0);
    `CHK(q[6:5], 2'b01)
    `CHK(int_pin, 1'b1)
    close_out();
  end
endmodule : tb
